// ==== pkg/adc_seq_pkg.sv ====
/*
 * Shared constants for the conversion sequencer: register map, field
 * positions, reset values, divider figures and sequence lengths.
 * Assumes a 250 MHz core clock that also stands for the device oscillator.
 */
package adc_seq_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] RESULT_OFS = 8'h04;
    localparam logic [7:0] PIN_CFG_OFS = 8'h08;
    localparam logic [7:0] PORT_DIR_OFS = 8'h0C;
    localparam logic [7:0] PORT_DATA_OFS = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h18;

    // ------------------------------------------------------------
    // Control register fields and the done interrupt bit
    // ------------------------------------------------------------
    localparam int POWER_ON_BIT = 0;
    localparam int GO_BIT = 2;
    localparam int CHAN_LSB = 3;
    localparam int CLK_SEL_LSB = 6;
    localparam int DONE_IRQ_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [7:0] PORT_DIR_RST = 8'hFF;
    localparam logic [1:0] PIN_CFG_RST = 2'h0;

    // ------------------------------------------------------------
    // Clock select codes and half bit periods in core cycles
    // ------------------------------------------------------------
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_RC = 2'h3;
    localparam int OSC_PER_DIV2 = 2;
    localparam int OSC_PER_DIV8 = 8;
    localparam int OSC_PER_DIV32 = 32;
    localparam logic [4:0] HALF_DIV2 = 5'(OSC_PER_DIV2 / 2);
    localparam logic [4:0] HALF_DIV8 = 5'(OSC_PER_DIV8 / 2);
    localparam logic [4:0] HALF_DIV32 = 5'(OSC_PER_DIV32 / 2);

    // ------------------------------------------------------------
    // Sequence lengths in half bit periods
    // ------------------------------------------------------------
    localparam logic [4:0] SETTLE_HALVES = 5'd3;
    localparam logic [4:0] CONV_HALVES = 5'd19;
    localparam logic [4:0] HOLDOFF_HALVES = 5'd4;

    typedef enum {ST_ACQ, ST_CONV, ST_HOLD} seq_state_t;

endpackage : adc_seq_pkg

// ==== verilog/bit_period_gen.sv ====
/*
 * Bit period generator: emits a one-cycle pulse every half bit period,
 * from the core clock by the selected divider or from the RC clock pin.
 * Assumes the RC clock pin is asynchronous and much slower than the core.
 */
`timescale 1ns/1ps
module bit_period_gen
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic run_i,
    input wire logic [1:0] clk_sel_i,
    input wire logic rc_clk_i,
    // Output
    output logic half_tick_o
);

    logic [4:0] cnt_r;
    logic [4:0] half_len;
    logic rc_meta_r;
    logic rc_sync_r;
    logic rc_last_r;

    always_comb
    begin
        unique case (clk_sel_i)
            CLK_DIV2: half_len = HALF_DIV2;
            CLK_DIV8: half_len = HALF_DIV8;
            CLK_DIV32: half_len = HALF_DIV32;
            CLK_RC: half_len = HALF_DIV2;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !run_i || cnt_r == half_len - 5'd1)
            cnt_r <= 5'd0;
        else
            cnt_r <= cnt_r + 5'd1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rc_meta_r <= 1'b0;
            rc_sync_r <= 1'b0;
            rc_last_r <= 1'b0;
        end
        else
        begin
            rc_meta_r <= rc_clk_i;
            rc_sync_r <= rc_meta_r;
            rc_last_r <= rc_sync_r;
        end
    end

    // each RC edge is half a bit period
    assign half_tick_o = run_i && ((clk_sel_i == CLK_RC) ? (rc_sync_r ^ rc_last_r)
                                                          : (cnt_r == half_len - 5'd1));

endmodule : bit_period_gen

// ==== verilog/sar_engine.sv ====
/*
 * Successive approximation register: trial code out, comparator in,
 * one bit decided per step, most significant first.
 * Assumes the comparator output is settled when a step arrives.
 */
`timescale 1ns/1ps
module sar_engine
    import adc_seq_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Sequence control
    input wire logic clear_i,
    input wire logic step_i,
    input wire logic comp_i,
    // Results
    output logic [WIDTH-1:0] trial_o,
    output logic [WIDTH-1:0] result_o,
    output logic done_o
);

    logic [WIDTH-1:0] bits_r;
    logic [WIDTH-1:0] mask_r;

    if (WIDTH < 2 || WIDTH > 16)
    begin : g_width_chk
        $error("sar_engine WIDTH out of range");
    end

    assign trial_o = bits_r | mask_r;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || clear_i)
        begin
            bits_r <= '0;
            mask_r <= {1'b1, {(WIDTH-1){1'b0}}};
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= step_i && mask_r[0];
            if (step_i && mask_r != '0)
            begin
                for (int i = 0; i < WIDTH; i++)
                begin
                    if (mask_r[i])
                        bits_r[i] <= comp_i;
                end
                mask_r <= mask_r >> 1;
            end
        end
    end

    assign result_o = bits_r;

endmodule : sar_engine

// ==== verilog/adc_conversion_sequencer.sv ====
/*
 * Conversion sequencer top: AHB-Lite register slave, acquisition,
 * conversion, hold-off and abort sequencing, port read-back masking
 * and the done interrupt.
 * Assumes one 250 MHz clock standing in for the device oscillator, an
 * external comparator and trial DAC, and a master doing single words.
 */
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module adc_conversion_sequencer
    import adc_seq_pkg::*;
#(
    parameter int RES_BITS = 8,
    parameter int PORT_WIDTH = 8
)
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [7:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic [31:0] HRDATA_O,
    // Analog front end
    input wire logic RC_CLK_I,
    input wire logic COMP_I,
    output logic [RES_BITS-1:0] DAC_O,
    output logic [2:0] CHAN_SEL_O,
    output logic SAMPLE_O,
    // Port pins
    input wire logic [PORT_WIDTH-1:0] PORT_PIN_I,
    output logic [PORT_WIDTH-1:0] PORT_OUT_O,
    output logic [PORT_WIDTH-1:0] PORT_OE_N_O,
    // Interrupt
    output logic IRQ_O
);

    // Reset value is byte wide and the analog mask sets four pins, so ports run from four to eight pins
    if (RES_BITS != 8)
    begin : g_res_chk
        $error("RES_BITS must be 8 for the 9.5 period sequence");
    end
    if (PORT_WIDTH < 4 || PORT_WIDTH > 8)
    begin : g_port_chk
        $error("PORT_WIDTH out of range");
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic power_on_r;
    logic go_r;
    logic [2:0] chan_r;
    logic [1:0] clk_sel_r;
    logic [RES_BITS-1:0] result_r;
    logic [1:0] pin_cfg_r;
    logic [PORT_WIDTH-1:0] dir_r;
    logic [PORT_WIDTH-1:0] port_out_r;
    logic irq_stat_r;
    logic irq_mask_r;

    // ------------------------------------------------------------
    // Bus phase capture
    // ------------------------------------------------------------
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic addr_phase;
    logic wr_now;

    // ------------------------------------------------------------
    // Sequencer signals
    // ------------------------------------------------------------
    seq_state_t state_r;
    logic [4:0] half_cnt_r;
    logic half_tick;
    logic sar_step;
    logic sar_done;
    logic sar_clear;
    logic [RES_BITS-1:0] sar_result;
    logic conv_done;
    logic go_wr_clear;

    function automatic logic [PORT_WIDTH-1:0] analog_mask(input logic [1:0] cfg);
        logic [PORT_WIDTH-1:0] m;
        m = '0;
        unique case (cfg)
            2'h0: m[3:0] = 4'hF;
            2'h1: m[3:0] = 4'hF;
            2'h2: m[1:0] = 2'h3;
            2'h3: m = '0;
        endcase
        return m;
    endfunction : analog_mask

    assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];
    assign wr_now = wr_pend_r;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!NRST_I)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else
        begin
            wr_pend_r <= addr_phase && HWRITE_I;
            if (addr_phase)
                wr_addr_r <= HADDR_I;
        end
    end

    // ------------------------------------------------------------
    // Read data, registered in the address phase
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!NRST_I)
            HRDATA_O <= 32'h00000000;
        else if (addr_phase && !HWRITE_I)
        begin
            HRDATA_O <= 32'h00000000;
            unique case (HADDR_I)
                CTRL_OFS:
                begin
                    HRDATA_O[POWER_ON_BIT] <= power_on_r;
                    HRDATA_O[GO_BIT] <= go_r;
                    HRDATA_O[CHAN_LSB +: 3] <= chan_r;
                    HRDATA_O[CLK_SEL_LSB +: 2] <= clk_sel_r;
                end
                RESULT_OFS: HRDATA_O[RES_BITS-1:0] <= result_r;
                PIN_CFG_OFS: HRDATA_O[1:0] <= pin_cfg_r;
                PORT_DIR_OFS: HRDATA_O[PORT_WIDTH-1:0] <= dir_r;
                PORT_DATA_OFS: HRDATA_O[PORT_WIDTH-1:0] <= PORT_PIN_I & ~analog_mask(pin_cfg_r);
                IRQ_STATUS_OFS: HRDATA_O[DONE_IRQ_BIT] <= irq_stat_r;
                IRQ_MASK_OFS: HRDATA_O[DONE_IRQ_BIT] <= irq_mask_r;
                default: HRDATA_O <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    assign go_wr_clear = wr_now && wr_addr_r == CTRL_OFS && !HWDATA_I[GO_BIT];

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!NRST_I)
        begin
            power_on_r <= 1'b0;
            chan_r <= 3'h0;
            clk_sel_r <= CLK_DIV2;
        end
        else if (wr_now && wr_addr_r == CTRL_OFS)
        begin
            power_on_r <= HWDATA_I[POWER_ON_BIT];
            chan_r <= HWDATA_I[CHAN_LSB +: 3];
            clk_sel_r <= HWDATA_I[CLK_SEL_LSB +: 2];
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!NRST_I || conv_done)
            go_r <= 1'b0;
        else if (wr_now && wr_addr_r == CTRL_OFS)
            go_r <= HWDATA_I[GO_BIT];
    end

    // ------------------------------------------------------------
    // Result register
    // ------------------------------------------------------------
    // only completion or software loads it
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!NRST_I)
            result_r <= RESULT_RST;
        else if (conv_done)
            result_r <= sar_result;
        else if (wr_now && wr_addr_r == RESULT_OFS)
            result_r <= HWDATA_I[RES_BITS-1:0];
    end

    // ------------------------------------------------------------
    // Port configuration and output latch
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!NRST_I)
        begin
            pin_cfg_r <= PIN_CFG_RST;
            dir_r <= PORT_DIR_RST[PORT_WIDTH-1:0];
            port_out_r <= '0;
        end
        else if (wr_now)
        begin
            if (wr_addr_r == PIN_CFG_OFS)
                pin_cfg_r <= HWDATA_I[1:0];
            if (wr_addr_r == PORT_DIR_OFS)
                dir_r <= HWDATA_I[PORT_WIDTH-1:0];
            if (wr_addr_r == PORT_DATA_OFS)
                port_out_r <= HWDATA_I[PORT_WIDTH-1:0];
        end
    end

    // Direction bit 1 means input; enable low drives the pin
    assign PORT_OUT_O = port_out_r;
    assign PORT_OE_N_O = dir_r;

    // ------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------
    // done flag, set wins over clear
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!NRST_I)
            irq_stat_r <= 1'b0;
        else if (conv_done)
            irq_stat_r <= 1'b1;
        else if (wr_now && wr_addr_r == IRQ_STATUS_OFS && HWDATA_I[DONE_IRQ_BIT])
            irq_stat_r <= 1'b0;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!NRST_I)
            irq_mask_r <= 1'b0;
        else if (wr_now && wr_addr_r == IRQ_MASK_OFS)
            irq_mask_r <= HWDATA_I[DONE_IRQ_BIT];
    end

    assign IRQ_O = irq_stat_r && irq_mask_r;

    // ------------------------------------------------------------
    // Bit period source
    // ------------------------------------------------------------
    bit_period_gen u_bit_period_gen (
        .clk_i(CORE_CLK_I),
        .rst_n_i(NRST_I),
        .run_i(state_r != ST_ACQ),
        .clk_sel_i(clk_sel_r),
        .rc_clk_i(RC_CLK_I),
        .half_tick_o(half_tick)
    );

    // ------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------
    // start depends only on power and start bit
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!NRST_I)
        begin
            state_r <= ST_ACQ;
            half_cnt_r <= 5'd0;
        end
        else
        begin
            unique case (state_r)
                ST_ACQ:
                begin
                    half_cnt_r <= 5'd0;
                    if (power_on_r && go_r && !go_wr_clear)
                        state_r <= ST_CONV;
                end
                ST_CONV:
                begin
                    if (go_wr_clear || !power_on_r)
                    begin
                        state_r <= ST_HOLD;
                        half_cnt_r <= 5'd0;
                    end
                    else if (conv_done)
                    begin
                        state_r <= ST_HOLD;
                        half_cnt_r <= 5'd0;
                    end
                    // nineteen half periods then stop counting
                    else if (half_tick && half_cnt_r != CONV_HALVES)
                        half_cnt_r <= half_cnt_r + 5'd1;
                end
                ST_HOLD:
                begin
                    if (half_tick && half_cnt_r == HOLDOFF_HALVES - 5'd1)
                        state_r <= ST_ACQ;
                    if (half_tick)
                        half_cnt_r <= half_cnt_r + 5'd1;
                end
            endcase
        end
    end

    // a bit decided at the end of each full period after settling
    assign sar_step = state_r == ST_CONV && half_tick && half_cnt_r > SETTLE_HALVES
                      && !half_cnt_r[0] && half_cnt_r < CONV_HALVES;
    assign sar_clear = state_r != ST_CONV;
    assign conv_done = state_r == ST_CONV && sar_done && go_r && !go_wr_clear && power_on_r;

    sar_engine #(
        .WIDTH(RES_BITS)
    ) u_sar_engine (
        .clk_i(CORE_CLK_I),
        .rst_n_i(NRST_I),
        .clear_i(sar_clear),
        .step_i(sar_step),
        .comp_i(COMP_I),
        .trial_o(DAC_O),
        .result_o(sar_result),
        .done_o(sar_done)
    );

    // ------------------------------------------------------------
    // Analog front end controls
    // ------------------------------------------------------------
    // capacitor disconnected outside acquisition
    assign SAMPLE_O = state_r == ST_ACQ && power_on_r;
    assign CHAN_SEL_O = chan_r;

endmodule : adc_conversion_sequencer

// ==== tb/adc_conversion_sequencer_sva.sv ====
/*
 * Checker for the conversion sequencer: bus answer, read data hold,
 * sequencing, port and interrupt relations.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module adc_conversion_sequencer_sva
    import adc_seq_pkg::*;
#(
    parameter int RES_BITS = 8,
    parameter int PORT_WIDTH = 8
)
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // Bus
    input wire logic HSEL_I,
    input wire logic [7:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic [31:0] HRDATA_O,
    // Front end and pins
    input wire logic RC_CLK_I,
    input wire logic COMP_I,
    input wire logic [RES_BITS-1:0] DAC_O,
    input wire logic [2:0] CHAN_SEL_O,
    input wire logic SAMPLE_O,
    input wire logic [PORT_WIDTH-1:0] PORT_PIN_I,
    input wire logic [PORT_WIDTH-1:0] PORT_OUT_O,
    input wire logic [PORT_WIDTH-1:0] PORT_OE_N_O,
    input wire logic IRQ_O
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic wr_ph_r;
    wire rd_req = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;

    // Marks the data phase of a write, when registers may change
    always_ff @(posedge CORE_CLK_I)
        wr_ph_r <= NRST_I & HSEL_I & HREADY_I & HTRANS_I[1] & HWRITE_I;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!NRST_I);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_start;
        $fell(SAMPLE_O);
    endsequence
    sequence s_low;
        !SAMPLE_O [*4];
    endsequence

    property p_ready; HREADYOUT_O && !HRESP_O; endproperty
    property p_rdata; !rd_req |=> $stable(HRDATA_O); endproperty
    property p_dac_idle; SAMPLE_O |-> DAC_O == 8'h80; endproperty
    property p_conv_min; s_start |-> s_low; endproperty
    property p_chan; !wr_ph_r |=> $stable(CHAN_SEL_O); endproperty
    property p_dir; !wr_ph_r |=> $stable(PORT_OE_N_O); endproperty
    property p_irq_rise; $rose(IRQ_O) |-> $past(wr_ph_r) || !$past(SAMPLE_O); endproperty
    property p_irq_fall; $fell(IRQ_O) |-> $past(wr_ph_r); endproperty

    a_ready: assert property (p_ready) else $error("bus answer not ready/okay");
    a_rdata: assert property (p_rdata) else $error("read data moved");
    a_dac_idle: assert property (p_dac_idle) else $error("trial code not midscale");
    a_conv_min: assert property (p_conv_min) else $error("sample low too short");
    a_chan: assert property (p_chan) else $error("channel moved");
    a_dir: assert property (p_dir) else $error("direction moved");
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose unprompted");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell unprompted");
endmodule : adc_conversion_sequencer_sva

bind adc_conversion_sequencer adc_conversion_sequencer_sva #(
    .RES_BITS(RES_BITS),
    .PORT_WIDTH(PORT_WIDTH)
) i_adc_conversion_sequencer_sva (
    .CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
    .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .HRDATA_O(HRDATA_O), .RC_CLK_I(RC_CLK_I), .COMP_I(COMP_I), .DAC_O(DAC_O),
    .CHAN_SEL_O(CHAN_SEL_O), .SAMPLE_O(SAMPLE_O), .PORT_PIN_I(PORT_PIN_I),
    .PORT_OUT_O(PORT_OUT_O), .PORT_OE_N_O(PORT_OE_N_O), .IRQ_O(IRQ_O)
);

// ==== tb/adc_conversion_sequencer_tb_top.sv ====
/*
 * Testbench for the conversion sequencer: bus tasks, ideal comparator,
 * free running RC clock, reset, pins, conversions, interrupt, abort.
 * Assumes the zero wait bus slave and the package constants.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module adc_conversion_sequencer_tb_top
    import adc_seq_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic rc_clk = 1'b0;
    logic comp = 1'b0;
    logic [7:0] pin = 8'hFF;
    logic [7:0] vin = 8'h00;
    logic [2:0] rc_cnt = 3'h0;
    logic hreadyout, hresp, sample, irq;
    logic [31:0] hrdata;
    logic [7:0] dac, pout, poe_n;
    logic [2:0] chan;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    adc_conversion_sequencer i_adc_conversion_sequencer (
        .CORE_CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hreadyout), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
        .HRDATA_O(hrdata), .RC_CLK_I(rc_clk), .COMP_I(comp), .DAC_O(dac),
        .CHAN_SEL_O(chan), .SAMPLE_O(sample), .PORT_PIN_I(pin), .PORT_OUT_O(pout),
        .PORT_OE_N_O(poe_n), .IRQ_O(irq)
    );

    always #2 clk = ~clk;

    // Ideal comparator and a slow RC clock, both launched on the edge
    always @(posedge clk)
    begin
        comp <= (vin >= dac);
        rc_cnt <= rc_cnt + 3'h1;
        if (rc_cnt == 3'h7)
            rc_clk <= ~rc_clk;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        `CHK(x, e)
    endtask : rd_chk

    // Cycles until the interrupt (0) or sampling (1) comes up
    task automatic wait_for(input bit s, output int n);
        n = 0;
        while ((s ? sample : irq) !== 1'b1 && n < 1000)
        begin
            @(posedge clk);
            n++;
        end
    endtask : wait_for

    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] ctl;
        int n;
        int h;
        static logic [7:0] pin_exp [4] = '{8'hF0, 8'hF0, 8'hFC, 8'hFF};
        static logic [7:0] vtab [4] = '{8'hA5, 8'h00, 8'hFF, 8'h3C};
        static int hp [4] = '{1, 4, 16, 8};
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd_chk(RESULT_OFS, 32'h0);
        rd_chk(PORT_DIR_OFS, 32'hFF);
        rd_chk(PIN_CFG_OFS, 32'h0);
        wr(8'h1C, 32'hFFFFFFFF);
        rd_chk(8'h1C, 32'h0);
        `CHK(poe_n, 8'hFF)
        `CHK(dac, 8'h80)
        $display("test reset done");
        for (int c = 0; c < 4; c++)
        begin
            wr(PIN_CFG_OFS, c);
            rd_chk(PORT_DATA_OFS, {24'h0, pin_exp[c]});
        end
        wr(PORT_DATA_OFS, 32'hA5);
        wr(PORT_DIR_OFS, 32'h0F);
        @(posedge clk);
        `CHK(pout, 8'hA5)
        `CHK(poe_n, 8'h0F)
        $display("test pins done");
        wr(IRQ_MASK_OFS, 32'h1);
        // Every clock select, with digital pins and outputs mixed in
        for (int s = 0; s < 4; s++)
        begin
            vin <= vtab[s];
            h = hp[s];
            ctl = {24'h0, 2'(s), 3'(s + 1), 3'h1};
            wr(PIN_CFG_OFS, s);
            // Odd passes keep pins as inputs, even ones drive them
            wr(PORT_DIR_OFS, (s % 2) ? 32'hFF : 32'h0);
            // Ideal comparator tolerates the short bit periods of this clock
            wr(CTRL_OFS, ctl);
            repeat (40) @(posedge clk);
            `CHK(chan, 3'(s + 1))
            wr(CTRL_OFS, ctl | 32'h4);
            wait_for(0, n);
            `CHK(n >= 18 * h && n <= 21 * h + 4, 1'b1)
            wait_for(1, n);
            `CHK(n >= 3 * h && n <= 4 * h + 4, 1'b1)
            rd_chk(RESULT_OFS, {24'h0, vtab[s]});
            rd_chk(CTRL_OFS, ctl);
            rd_chk(IRQ_STATUS_OFS, 32'h1);
            wr(IRQ_MASK_OFS, 32'h0);
            @(posedge clk);
            `CHK(irq, 1'b0)
            wr(IRQ_MASK_OFS, 32'h1);
            @(posedge clk);
            `CHK(irq, 1'b1)
            wr(IRQ_STATUS_OFS, 32'h1);
            @(posedge clk);
            `CHK(irq, 1'b0)
        end
        $display("test conversions done");
        // Abort mid-conversion keeps the software result
        wr(RESULT_OFS, 32'h5A);
        ctl = 32'h51;
        wr(CTRL_OFS, ctl);
        repeat (40) @(posedge clk);
        wr(CTRL_OFS, ctl | 32'h4);
        repeat (20) @(posedge clk);
        `CHK(sample, 1'b0)
        wr(CTRL_OFS, ctl);
        wait_for(1, n);
        `CHK(n >= 8 && n <= 24, 1'b1)
        `CHK(irq, 1'b0)
        rd_chk(RESULT_OFS, 32'h5A);
        rd_chk(IRQ_STATUS_OFS, 32'h0);
        // Power off mid-conversion aborts too; start bit stays set
        repeat (40) @(posedge clk);
        wr(CTRL_OFS, ctl | 32'h4);
        repeat (20) @(posedge clk);
        wr(CTRL_OFS, 32'h54);
        repeat (100) @(posedge clk);
        `CHK(sample, 1'b0)
        `CHK(irq, 1'b0)
        rd_chk(RESULT_OFS, 32'h5A);
        rd_chk(CTRL_OFS, 32'h54);
        $display("test abort done");
        summarize();
    end
endmodule : adc_conversion_sequencer_tb_top
